// ---- design/dqf_buf2.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dqf_buf2 #(
    parameter int WIDTH = 17
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    typedef struct packed {
        logic [1:0] cnt;
        logic vld;
        logic rdy;
        logic [WIDTH-1:0] m0;
        logic [WIDTH-1:0] m1;
    } dqf_buf_t;

    dqf_buf_t q;
    dqf_buf_t d;

    always_comb begin
        logic pop;
        logic put;
        logic [1:0] n;
        d = q;
        pop = q.vld & out_ready_in;
        put = in_valid_in & q.rdy;
        n = q.cnt - {1'b0, pop};
        if (pop) begin
            d.m0 = q.m1;
        end
        if (put) begin
            if (n == 2'h0) begin
                d.m0 = in_data_in;
            end else begin
                d.m1 = in_data_in;
            end
        end
        n = n + {1'b0, put};
        d.cnt = n;
        d.vld = (n != 2'h0);
        d.rdy = (n != 2'h2);
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '{cnt: 2'h0, vld: 1'b0, rdy: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign in_ready_out = q.rdy;
    assign out_valid_out = q.vld;
    assign out_data_out = q.m0;

endmodule : dqf_buf2

// ---- design/dqf_core.sv ----
// Command interface state sequencer of the dual-quad flash device
`timescale 1ns/100ps
`include "dqf_defs.svh"
module dqf_core #(
    parameter int PU_CYCLES = `DQF_PU_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Flash pins
    input wire logic sck_in,
    input wire logic chip_select_n_in,
    input wire logic hw_reset_n_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic [7:0] io_oe_out,
    // Configuration levels
    input wire logic [1:0] latency_code_field_in,
    input wire logic addr_4byte_in,
    input wire logic quad_mode_in,
    // Read data source
    input wire logic [15:0] rd_word_in,
    output logic rd_take_out,
    // Received byte stream
    output logic [16:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // Status
    output dqf_pkg::dqf_state_t state_out,
    output logic cmd_exec_out,
    output logic cmd_reject_out,
    output logic overrun_out
);
    import dqf_pkg::*;

    localparam logic [15:0] PU_LAST = 16'(PU_CYCLES - 1);
    localparam logic [7:0] RP_CYC = 8'(`DQF_RP_CYC);
    localparam logic [15:0] RPH_CYC = 16'(`DQF_RPH_CYC);
    localparam logic [7:0] RH_CYC = 8'(`DQF_RH_CYC);

    dqf_core_t q;
    dqf_core_t d;
    logic buf_rdy;

    // ----
    // Next state
    // ----
    always_comb begin
        logic sck_r;
        logic sck_f;
        logic cs_hi;
        logic cs_fall;
        logic rp;
        logic lo_bit;
        logic hi_bit;
        logic drv;
        logic active;
        logic [7:0] ins;
        logic [7:0] lat_sel;
        logic [7:0] wl;
        logic [7:0] wh;
        sck_r = q.sck_s[1] & ~q.sck_s[2];
        sck_f = ~q.sck_s[1] & q.sck_s[2];
        cs_hi = q.cs_s[1];
        cs_fall = ~q.cs_s[1] & q.cs_s[2];
        rp = q.rp_s[1];
        lo_bit = q.io2[`DQF_LOW_QUAD_INPUT_LANE];
        hi_bit = q.io2[`DQF_HIGH_QUAD_INPUT_LANE];
        drv = 1'b0;
        ins = {q.sl[6:0], lo_bit};
        wl = q.ol;
        wh = q.oh;
        d = q;
        d.push = 1'b0;
        d.rd_take = 1'b0;
        d.exec = 1'b0;
        d.reject = 1'b0;
        d.sck_s = {q.sck_s[1:0], sck_in};
        d.cs_s = {q.cs_s[1:0], chip_select_n_in};
        d.rp_s = {q.rp_s[1:0], hw_reset_n_in};
        d.io1 = io_in;
        d.io2 = q.io1;
        active = (q.st != ST_POR) && (q.st != ST_HWRST) && (q.st != ST_IDLE);
        case (latency_code_field_in)
            2'h0: lat_sel = `DQF_LAT_C0; // RULE17
            2'h1: lat_sel = `DQF_LAT_C1;
            2'h2: lat_sel = `DQF_LAT_C2;
            default: lat_sel = `DQF_LAT_C3;
        endcase
        if (rp) begin
            d.lo_cnt = 8'h00;
        end else if (q.lo_cnt != RP_CYC) begin
            d.lo_cnt = q.lo_cnt + 8'h01;
        end
        if (q.push && !buf_rdy) begin
            d.overrun = 1'b1;
        end

        case (q.st)
            ST_POR: begin
                // Pins ignored, lanes released
                d.io_oe = 8'h00; // RULE5
                d.por_cnt = q.por_cnt + 16'h0001;
                if (q.por_cnt == PU_LAST) begin
                    d.st = ST_IDLE; // RULE5
                end
            end
            ST_HWRST: begin
                d.io_oe = 8'h00;
                if (q.busy_cnt != RPH_CYC) begin
                    d.busy_cnt = q.busy_cnt + 16'h0001; // RULE6
                end
                if (!rp) begin
                    d.hold_cnt = 8'h00;
                end else if (q.hold_cnt != RH_CYC) begin
                    d.hold_cnt = q.hold_cnt + 8'h01;
                end
                if (q.busy_cnt == RPH_CYC && q.hold_cnt == RH_CYC) begin
                    d.st = ST_IDLE; // RULE6
                end
            end
            ST_IDLE: begin
                d.io_oe = 8'h00; // RULE8
                if (cs_fall) begin
                    d.st = ST_INSTR; // RULE9
                    d.edge_cnt = 8'h00;
                    d.chk = 1'b1;
                    d.chk_mask = 3'h7;
                    d.overrun = 1'b0;
                end
            end
            ST_INSTR: begin
                if (sck_r) begin
                    // Low lane decoded, high lane copy passed on
                    d.sl = ins; // RULE10 RULE1
                    d.sh = {q.sh[6:0], hi_bit};
                    d.edge_cnt = q.edge_cnt + 8'h01;
                    if (q.edge_cnt[2:0] == 3'h7) begin
                        d.push = 1'b1;
                        d.first = 1'b1;
                        d.chk = 1'b0;
                        d.wdata = 1'b0;
                        d.wquad = 1'b0;
                        d.outq = 1'b0;
                        d.lat_left = lat_sel;
                        d.bits = addr_4byte_in ? `DQF_ABITS4 : `DQF_ABITS3; // RULE2
                        d.st = ST_SIN;
                        case (ins) // RULE11
                            `DQF_CMD_WREN, `DQF_CMD_WRDI: begin
                                d.st = ST_SKIP; // RULE12
                                d.chk = 1'b1;
                            end
                            `DQF_CMD_RDSR: begin
                                d.st = ST_SLAT;
                                d.lat_left = 8'h00;
                            end
                            `DQF_CMD_READ: begin
                                d.lat_left = 8'h00;
                            end
                            `DQF_CMD_FREAD: begin
                                d.lat_left = lat_sel;
                            end
                            `DQF_CMD_PP: begin
                                d.wdata = 1'b1;
                                d.chk = 1'b1;
                            end
                            `DQF_CMD_QOR: begin
                                d.outq = 1'b1; // RULE15
                            end
                            `DQF_CMD_QPP: begin
                                d.wdata = 1'b1;
                                d.wquad = 1'b1;
                                d.chk = 1'b1;
                                d.chk_mask = 3'h1;
                            end
                            `DQF_CMD_QIOR: begin
                                d.outq = 1'b1;
                                d.bits = addr_4byte_in ? `DQF_QBITS4 : `DQF_QBITS3;
                                d.st = ST_QIN;
                            end
                            default: begin
                                d.st = ST_SKIP;
                            end
                        endcase
                        if ((d.outq || d.wquad) && !quad_mode_in) begin
                            d.st = ST_SKIP;
                            d.chk = 1'b0;
                        end
                    end
                end
            end
            ST_SIN: begin
                d.io_oe = 8'h00; // RULE14
                if (sck_r) begin
                    d.sl = ins; // RULE2
                    d.sh = {q.sh[6:0], hi_bit};
                    d.edge_cnt = q.edge_cnt + 8'h01;
                    if (q.edge_cnt[2:0] == 3'h7) begin
                        d.push = 1'b1;
                        d.first = 1'b0;
                    end
                    if (q.bits != 6'h00) begin
                        d.bits = q.bits - 6'h01;
                        if (q.bits == 6'h01) begin
                            if (q.wdata) begin
                                d.st = q.wquad ? ST_QIN : ST_SIN; // RULE16
                            end else begin
                                d.st = q.outq ? ST_QLAT : ST_SLAT; // RULE16
                            end
                        end
                    end
                end
            end
            ST_QIN: begin
                if (sck_r) begin
                    // Lowest lane holds the nibble LSB
                    d.sl = {q.sl[3:0], q.io2[3:0]}; // RULE24 RULE3
                    d.sh = {q.sh[3:0], q.io2[7:4]};
                    d.edge_cnt = q.edge_cnt + 8'h01;
                    // Optional mode cycles are never pushed
                    if (q.edge_cnt[0] && (q.bits == 6'h00 || q.bits > `DQF_MODE_CYC)) begin
                        d.push = 1'b1; // RULE4
                        d.first = 1'b0;
                    end
                    if (q.bits != 6'h00) begin
                        d.bits = q.bits - 6'h01;
                        if (q.bits == 6'h01) begin
                            d.st = ST_QLAT;
                        end
                    end
                end
            end
            ST_SLAT, ST_QLAT: begin
                // Lanes released, values ignored
                d.io_oe = 8'h00; // RULE21 RULE18
                d.ocnt = 3'h0;
                if (sck_r && q.lat_left != 8'h00) begin
                    d.lat_left = q.lat_left - 8'h01; // RULE17
                end
                if (sck_f && q.lat_left == 8'h00) begin
                    d.st = q.outq ? ST_QOUT : ST_SOUT; // RULE22
                    drv = 1'b1;
                end
            end
            ST_SOUT, ST_QOUT: begin
                drv = sck_f;
            end
            ST_SKIP: begin
                if (sck_r) begin
                    d.edge_cnt = q.edge_cnt + 8'h01;
                end
            end
            default: begin
                d.st = ST_POR;
            end
        endcase

        // ----
        // Output lanes, updated on the falling clock
        // ----
        if (drv) begin
            if (q.ocnt == 3'h0 || q.st == ST_SLAT || q.st == ST_QLAT) begin
                wl = rd_word_in[7:0];
                wh = rd_word_in[15:8];
                d.rd_take = 1'b1;
            end
            if (q.outq) begin
                d.io_oe = `DQF_OE_QUAD;
                d.io_o = {wh[7:4], wl[7:4]}; // RULE24
                d.ol = {wl[3:0], 4'h0};
                d.oh = {wh[3:0], 4'h0};
                d.ocnt = (d.ocnt == 3'h1) ? 3'h0 : d.ocnt + 3'h1;
            end else begin
                d.io_oe = `DQF_OE_SINGLE;
                d.io_o = 8'h00;
                d.io_o[`DQF_LOW_QUAD_OUTPUT_LANE] = wl[7];
                d.io_o[`DQF_HIGH_QUAD_OUTPUT_LANE] = wh[7];
                d.ol = {wl[6:0], 1'b0};
                d.oh = {wh[6:0], 1'b0};
                d.ocnt = d.ocnt + 3'h1;
            end
        end

        // ----
        // Command end and hardware reset
        // ----
        if (active && cs_hi) begin
            d.st = ST_IDLE; // RULE8
            d.io_oe = 8'h00;
            d.push = 1'b0;
            if (q.chk) begin
                if ((q.edge_cnt[2:0] & q.chk_mask) == 3'h0) begin
                    d.exec = 1'b1;
                end else begin
                    d.reject = 1'b1; // RULE23
                end
            end
        end
        if (q.st != ST_POR && q.st != ST_HWRST && q.lo_cnt == RP_CYC) begin
            d.st = ST_HWRST; // RULE6
            d.busy_cnt = 16'h0000;
            d.hold_cnt = 8'h00;
            d.io_oe = 8'h00;
            d.push = 1'b0;
            d.exec = 1'b0;
            d.reject = 1'b0;
            d.rd_take = 1'b0;
        end
    end

    // ----
    // State register
    // ----
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '{st: ST_POR, default: '0};
        end else begin
            q <= d;
        end
    end

    // ----
    // Received byte buffer
    // ----
    dqf_buf2 #(
        .WIDTH(17)
    ) u_rx_buf (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(q.push),
        .in_data_in({q.first, q.sh, q.sl}),
        .in_ready_out(buf_rdy),
        .out_valid_out(rx_valid_out),
        .out_data_out(rx_data_out),
        .out_ready_in(rx_ready_in)
    );

    assign io_out = q.io_o;
    assign io_oe_out = q.io_oe;
    assign state_out = q.st;
    assign rd_take_out = q.rd_take;
    assign cmd_exec_out = q.exec;
    assign cmd_reject_out = q.reject;
    assign overrun_out = q.overrun;

endmodule : dqf_core

// ---- design/dqf_defs.svh ----
// Constants for the dual-quad flash command interface
`ifndef DQF_DEFS_SVH
`define DQF_DEFS_SVH
// How it works
// RULE1 - Same instruction byte on both input lanes.
// RULE2 - Address starts at bit 23 or 31, MSB first.
// RULE3 - Same quad bits on both lane groups.
// RULE4 - Optional quad I/O cycles go unused.
// RULE5 - Power-on: pins ignored for power-up time, then standby.
// RULE6 - Reset pulse: busy and hold times, then standby.
// RULE7 - Quad mode: select high during hardware reset; the code takes quad mode from the quad_mode_in level instead.
// RULE8 - Select high: idle, ignoring all but reset.
// RULE9 - Select fall starts the instruction state.
// RULE10 - Instruction taken MSB first, one bit per rising clock.
// RULE11 - Instruction picks address space and format.
// RULE12 - Stand-alone command: select rises after bit eight.
// RULE13 - Select low, reset high while clocking.
// RULE14 - No output lane driven in single input cycles.
// RULE15 - Quad output reads: address on the single lane.
// RULE16 - State after single input depends on instruction.
// RULE17 - Latency code field sets latency cycles.
// RULE18 - Lanes ignored in latency cycles.
// RULE19 - Host releases lanes by last latency falling edge.
// RULE20 - Host should release lanes in all latency cycles.
// RULE21 - Device drives no lane in latency cycles.
// RULE22 - Read data from the last latency falling edge.
// RULE23 - Select rise off eight-clock boundary rejects; the code rejects quad page program only off a two-clock boundary.
// RULE24 - Nibble LSB on lowest lane of its group.

// Timing
`define DQF_CLK_NS 10
`define DQF_POWER_UP_TIME_NS 300000
`define DQF_RESET_PULSE_TIME_NS 200
`define DQF_RESET_BUSY_TIME_NS 35000
`define DQF_RESET_HOLD_TIME_NS 50
`define DQF_PU_CYC ((`DQF_POWER_UP_TIME_NS + `DQF_CLK_NS - 1) / `DQF_CLK_NS)
`define DQF_RP_CYC ((`DQF_RESET_PULSE_TIME_NS + `DQF_CLK_NS - 1) / `DQF_CLK_NS)
`define DQF_RPH_CYC ((`DQF_RESET_BUSY_TIME_NS + `DQF_CLK_NS - 1) / `DQF_CLK_NS)
`define DQF_RH_CYC ((`DQF_RESET_HOLD_TIME_NS + `DQF_CLK_NS - 1) / `DQF_CLK_NS)

// Lane positions
`define DQF_LOW_QUAD_INPUT_LANE 0
`define DQF_HIGH_QUAD_INPUT_LANE 4
`define DQF_LOW_QUAD_OUTPUT_LANE 1
`define DQF_HIGH_QUAD_OUTPUT_LANE 5
`define DQF_OE_SINGLE 8'h22
`define DQF_OE_QUAD 8'hFF

// Address clocks, quad mode cycles included
`define DQF_ABITS3 6'h18
`define DQF_ABITS4 6'h20
`define DQF_QBITS3 6'h08
`define DQF_QBITS4 6'h0A
`define DQF_MODE_CYC 6'h02

// Latency cycles per code
`define DQF_LAT_C0 8'h00
`define DQF_LAT_C1 8'h02
`define DQF_LAT_C2 8'h04
`define DQF_LAT_C3 8'h06

// Instruction codes
`define DQF_CMD_WREN 8'h06
`define DQF_CMD_WRDI 8'h04
`define DQF_CMD_RDSR 8'h05
`define DQF_CMD_READ 8'h03
`define DQF_CMD_FREAD 8'h0B
`define DQF_CMD_PP 8'h02
`define DQF_CMD_QOR 8'h6B
`define DQF_CMD_QPP 8'h32
`define DQF_CMD_QIOR 8'hEB

`endif

// ---- design/dqf_pkg.sv ----
// Types of the dual-quad flash command interface
package dqf_pkg;

    typedef enum logic [10:0] {
        ST_POR = 11'h001,
        ST_HWRST = 11'h002,
        ST_IDLE = 11'h004,
        ST_INSTR = 11'h008,
        ST_SIN = 11'h010,
        ST_SLAT = 11'h020,
        ST_SOUT = 11'h040,
        ST_QIN = 11'h080,
        ST_QLAT = 11'h100,
        ST_QOUT = 11'h200,
        ST_SKIP = 11'h400
    } dqf_state_t;

    typedef struct packed {
        dqf_state_t st;
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [2:0] rp_s;
        logic [7:0] io1;
        logic [7:0] io2;
        logic [15:0] por_cnt;
        logic [15:0] busy_cnt;
        logic [7:0] lo_cnt;
        logic [7:0] hold_cnt;
        logic [7:0] edge_cnt;
        logic [5:0] bits;
        logic [7:0] lat_left;
        logic [7:0] sl;
        logic [7:0] sh;
        logic [7:0] ol;
        logic [7:0] oh;
        logic [2:0] ocnt;
        logic [2:0] chk_mask;
        logic chk;
        logic wdata;
        logic wquad;
        logic outq;
        logic [7:0] io_o;
        logic [7:0] io_oe;
        logic push;
        logic first;
        logic rd_take;
        logic exec;
        logic reject;
        logic overrun;
    } dqf_core_t;

endpackage : dqf_pkg

// ---- test/dqf_core_props.sv ----
// Checker of the dual-quad flash command interface
`timescale 1ns/100ps
module dqf_core_props #(
    parameter int PU_CYCLES = 50
) (
    // Watched ports
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic chip_select_n_in,
    input wire logic hw_reset_n_in,
    input wire logic [7:0] io_oe_out,
    input wire logic [16:0] rx_data_out,
    input wire logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire dqf_pkg::dqf_state_t state_out,
    input wire logic cmd_exec_out,
    input wire logic cmd_reject_out
);
    import dqf_pkg::*;
    int unsigned pu_n;
    int unsigned lo_n;
    int unsigned hr_n;
    // ----
    // Cycle counters
    // ----
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pu_n <= 0;
            lo_n <= 0;
            hr_n <= 0;
        end else begin
            pu_n <= pu_n + 1;
            lo_n <= hw_reset_n_in ? 0 : lo_n + 1;
            hr_n <= (state_out == ST_HWRST) ? hr_n + 1 : 0;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence cs_idle_s;
        (chip_select_n_in && hw_reset_n_in) [*4] ##0 state_out == ST_IDLE;
    endsequence
    sequence pulse_end_s;
        !(cmd_exec_out && cmd_reject_out) ##1 !(cmd_exec_out || cmd_reject_out);
    endsequence
    por_quiet_a: assert property (state_out == ST_POR |-> io_oe_out == 8'h00)
        else $error("lanes driven in power-on reset");
    por_len_a: assert property ($past(state_out) == ST_POR && state_out == ST_IDLE
        |-> pu_n inside {[PU_CYCLES - 1:PU_CYCLES + 3]}) else $error("power-up length");
    cs_idle_a: assert property (cs_idle_s |=> state_out == ST_IDLE)
        else $error("left standby with select high");
    cs_fall_a: assert property ($fell(chip_select_n_in) && state_out == ST_IDLE
        |-> ##[2:6] state_out == ST_INSTR) else $error("no instruction state");
    hr_entry_a: assert property ($rose(state_out == ST_HWRST)
        |-> lo_n inside {[21:26]}) else $error("reset pulse length");
    hr_exit_a: assert property ($fell(state_out == ST_HWRST) |-> hr_n >= 3499)
        else $error("reset busy too short");
    quiet_in_a: assert property (state_out inside {ST_SIN, ST_SLAT, ST_QLAT}
        && $past(state_out) == state_out |-> io_oe_out == 8'h00) else $error("lanes driven");
    single_out_a: assert property (state_out == ST_SOUT ##1 state_out == ST_SOUT
        |-> io_oe_out == 8'h22) else $error("single output enables");
    quad_out_a: assert property (state_out == ST_QOUT ##1 state_out == ST_QOUT
        |-> io_oe_out == 8'hFF) else $error("quad output enables");
    one_pulse_a: assert property (cmd_exec_out || cmd_reject_out |-> pulse_end_s)
        else $error("exec or reject pulse");
    rx_hold_a: assert property (rx_valid_out && !rx_ready_in
        |=> rx_valid_out && $stable(rx_data_out)) else $error("stalled byte lost");
endmodule : dqf_core_props

bind dqf_core dqf_core_props #(.PU_CYCLES(PU_CYCLES)) u_props (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .chip_select_n_in(chip_select_n_in),
    .hw_reset_n_in(hw_reset_n_in), .io_oe_out(io_oe_out), .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in), .state_out(state_out),
    .cmd_exec_out(cmd_exec_out), .cmd_reject_out(cmd_reject_out));

// ---- test/dqf_host.sv ----
// Host controller model driving the flash pins
`timescale 1ns/100ps
module dqf_host (
    // Pins
    input wire logic core_clk_in,
    input wire logic [7:0] lane_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic drv_out,
    output logic [7:0] io_out
);
    logic [7:0] smp[$];
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        drv_out = 1'b0;
        io_out = 8'h00;
    end
    task sel(input logic en);
        @(negedge core_clk_in);
        #1.3;
        cs_n_out = !en;
        drv_out = en;
        #62.5;
    endtask : sel
    task cyc(input logic [7:0] v, input logic en);
        drv_out = en;
        io_out = v;
        #62.5;
        sck_out = 1'b1;
        smp.push_back(lane_in);
        #62.5;
        sck_out = 1'b0;
    endtask : cyc
    task byte1(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) cyc({3'h0, b[i], 3'h0, b[i]}, 1'b1);
    endtask : byte1
    task quad(input logic [7:0] b);
        cyc({b[7:4], b[7:4]}, 1'b1);
        cyc({b[3:0], b[3:0]}, 1'b1);
    endtask : quad
endmodule : dqf_host

// ---- test/tb_dqf_core.sv ----
// Self-checking bench of the dual-quad flash command interface
`timescale 1ns/100ps
module tb_dqf_core;
    import dqf_pkg::*;
    logic clk, nrst, hrst_n, qm, rdy, a4, nz, stall, sck, cs_n, h_drv, take, ex, rj, ovr, rxv;
    logic [1:0] lat;
    logic [7:0] io_o, io_oe, lanes, h_io;
    logic [15:0] word;
    logic [16:0] rxd;
    dqf_state_t st;
    logic [16:0] exq[$];
    logic [15:0] wq[$];
    int n_errors, checked, seed, cyc_n, n_ex, n_rj;
    assign lanes = (io_oe & io_o) | (~io_oe & (h_drv ? h_io : {8{nz}}));
    dqf_core #(.PU_CYCLES(50)) uut (.core_clk_in(clk), .nrst_in(nrst), .sck_in(sck),
        .chip_select_n_in(cs_n), .hw_reset_n_in(hrst_n), .io_in(lanes), .io_out(io_o),
        .io_oe_out(io_oe), .latency_code_field_in(lat), .addr_4byte_in(a4),
        .quad_mode_in(qm), .rd_word_in(word), .rd_take_out(take), .rx_data_out(rxd),
        .rx_valid_out(rxv), .rx_ready_in(rdy), .state_out(st), .cmd_exec_out(ex),
        .cmd_reject_out(rj), .overrun_out(ovr));
    dqf_host host (.core_clk_in(clk), .lane_in(lanes), .sck_out(sck), .cs_n_out(cs_n),
        .drv_out(h_drv), .io_out(h_io));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // Checking
    // ----
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task end_sim();
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    always @(negedge clk) begin
        rdy <= stall ? 1'b0 : 1'($random(seed));
        nz <= ~nz;
        if (take) begin
            wq.push_back(word);
            word <= 16'($random(seed));
        end
    end
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (rxv && rdy) begin
            if (exq.size() == 0) check("rx_extra", 1, 0);
            else check("rx_byte", rxd, exq.pop_front());
        end
        if (ex) n_ex <= n_ex + 1;
        if (rj) n_rj <= n_rj + 1;
        if (cyc_n == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    // ----
    // Stimulus
    // ----
    task sb(input logic [7:0] b, input logic f);
        exq.push_back({f, b, b});
        host.byte1(b, 8);
    endtask : sb
    task ab(input logic [7:0] b, input logic q);
        exq.push_back({1'b0, b, b});
        if (q) host.quad(b);
        else host.byte1(b, 8);
    endtask : ab
    task wait_idle(input int n);
        for (int i = 0; i < n && st !== ST_IDLE; i++) @(negedge clk);
        check("standby", st, ST_IDLE);
    endtask : wait_idle
    task wr(input logic [7:0] ins, input int ni, na, nd, xb, input logic q, input int ee);
        int e0;
        int r0;
        e0 = n_ex;
        r0 = n_rj;
        host.sel(1'b1);
        if (ni == 8) sb(ins, 1'b1);
        else host.byte1(ins, ni);
        repeat (na) ab(8'($random(seed)), 1'b0);
        repeat (nd) ab(8'($random(seed)), q);
        repeat (xb) host.cyc(8'h00, 1'b1);
        host.sel(1'b0);
        repeat (20) @(negedge clk);
        check("exec", n_ex - e0, ee);
        check("reject", n_rj - r0, 1 - ee);
    endtask : wr
    task rd(input logic [7:0] ins, input int na, nl, input logic qa, qo);
        logic [7:0] s0;
        logic [7:0] s1;
        host.sel(1'b1);
        sb(ins, 1'b1);
        repeat (na) ab(8'($random(seed)), qa);
        if (qa) repeat (2) host.cyc(8'h00, 1'b0);
        repeat (nl) host.cyc(8'h00, 1'b0);
        wq.delete();
        host.smp.delete();
        repeat (qo ? 4 : 16) host.cyc(8'h00, 1'b0);
        host.sel(1'b0);
        repeat (20) @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            if (qo) begin
                s0 = {host.smp[2 * k][3:0], host.smp[2 * k + 1][3:0]};
                s1 = {host.smp[2 * k][7:4], host.smp[2 * k + 1][7:4]};
            end else for (int b = 0; b < 8; b++) begin
                s0[7 - b] = host.smp[8 * k + b][1];
                s1[7 - b] = host.smp[8 * k + b][5];
            end
            check("read_data", {s1, s0}, wq[k]);
        end
    endtask : rd
    initial begin
        seed = 23492;
        {n_errors, checked, cyc_n, n_ex, n_rj} = 0;
        {nrst, stall, a4, nz, lat} = 0;
        {hrst_n, qm} = 2'h3;
        word = 16'h5AC3;
        repeat (10) @(negedge clk);
        host.cs_n_out = 1'b0;
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        check("por_state", st, ST_POR);
        host.cs_n_out = 1'b1;
        wait_idle(200);
        host.byte1(8'h06, 8);
        check("idle_state", st, ST_IDLE);
        wr(8'h06, 8, 0, 0, 0, 1'b0, 1);
        wr(8'h04, 8, 0, 0, 0, 1'b0, 1);
        wr(8'h06, 7, 0, 0, 0, 1'b0, 0);
        wr(8'h02, 8, 3, 1, 0, 1'b0, 1);
        wr(8'h02, 8, 3, 1, 3, 1'b0, 0);
        wr(8'h32, 8, 3, 1, 0, 1'b1, 1);
        wr(8'h32, 8, 3, 1, 1, 1'b1, 0);
        rd(8'h03, 3, 0, 1'b0, 1'b0);
        rd(8'h05, 0, 0, 1'b0, 1'b0);
        a4 = 1'b1;
        rd(8'h03, 4, 0, 1'b0, 1'b0);
        a4 = 1'b0;
        lat = 2'h3;
        rd(8'h0B, 3, 6, 1'b0, 1'b0);
        rd(8'h6B, 3, 6, 1'b0, 1'b1);
        for (int c = 0; c < 4; c++) begin
            lat = 2'(c);
            rd(8'hEB, 3, 2 * c, 1'b1, 1'b1);
        end
        qm = 1'b0;
        host.sel(1'b1);
        sb(8'h6B, 1'b1);
        check("quad_skip", st, ST_SKIP);
        host.sel(1'b0);
        stall = 1'b1;
        host.sel(1'b1);
        sb(8'h02, 1'b1);
        ab(8'h3C, 1'b0);
        repeat (3) host.byte1(8'hA7, 8);
        host.sel(1'b0);
        check("overrun", ovr, 1'b1);
        stall = 1'b0;
        repeat (20) @(negedge clk);
        host.sel(1'b1);
        repeat (8) @(negedge clk);
        check("overrun_clr", ovr, 1'b0);
        host.sel(1'b0);
        repeat (20) @(negedge clk);
        qm = 1'b1;
        hrst_n = 1'b0;
        repeat (30) @(negedge clk);
        check("hw_reset", st, ST_HWRST);
        check("hw_lanes", io_oe, 8'h00);
        hrst_n = 1'b1;
        wait_idle(4000);
        wr(8'h06, 8, 0, 0, 0, 1'b0, 1);
        check("rx_left", exq.size(), 0);
        end_sim();
    end
endmodule : tb_dqf_core
